// ==== src/rsa_link_if.sv ====
// carrier between the sck-side shifter and the register core
// evt fields change on sck and then hold a byte time; snapshots hold still through a frame
interface rsa_link_if;
	import rsa_pkg::*;
	logic       evtToggle;
	logic       evtIsCmd;
	logic [7:0] evtByte;
	logic [7:0] statusSnap;
	rsa_map_t   regSnap;
	modport link (output evtToggle, output evtIsCmd, output evtByte, input statusSnap, input regSnap);
	modport core (input evtToggle, input evtIsCmd, input evtByte, output statusSnap, output regSnap);
endinterface

// ==== src/rsa_pkg.sv ====
// register map, field positions and reset values of the radio status/address bank
// assumes one-byte SPI commands: op in the top three bits, register in the low five
package rsa_pkg;
	localparam logic [4:0] OFS_ADDR_WIDTH = 5'h03;
	localparam logic [4:0] OFS_RETRANSMIT = 5'h04;
	localparam logic [4:0] OFS_CHANNEL    = 5'h05;
	localparam logic [4:0] OFS_RADIO_SET  = 5'h06;
	localparam logic [4:0] OFS_STATUS     = 5'h07;
	localparam logic [4:0] OFS_OBSERVE    = 5'h08;
	localparam logic [4:0] OFS_POWER_DET  = 5'h09;
	localparam logic [4:0] OFS_PIPE0_ADDR = 5'h0a;
	localparam logic [4:0] OFS_PIPE1_ADDR = 5'h0b;
	localparam logic [4:0] OFS_PIPE2_LOW  = 5'h0c;
	localparam logic [4:0] OFS_PIPE3_LOW  = 5'h0d;

	localparam logic [2:0] CMD_READ  = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;

	localparam int ST_RX_READY  = 6;
	localparam int ST_TX_SENT   = 5;
	localparam int ST_RETRY_LIM = 4;
	localparam int SET_PWR_LSB  = 1;
	localparam int SET_CARRIER  = 7;
	localparam int SET_LOW_RATE = 5;
	localparam int SET_HI_RATE  = 3;
	localparam int RETR_DLY_LSB = 4;

	localparam logic [7:0]  RST_ADDR_WIDTH = 8'h03;
	localparam logic [7:0]  RST_RETRANSMIT = 8'h03;
	localparam logic [7:0]  RST_CHANNEL    = 8'h02;
	localparam logic [7:0]  RST_RADIO_SET  = 8'h0e;
	localparam logic [39:0] RST_PIPE0_ADDR = 40'he7e7e7e7e7;
	localparam logic [39:0] RST_PIPE1_ADDR = 40'hc2c2c2c2c2;
	localparam logic [7:0]  RST_PIPE2_LOW  = 8'hc3;
	localparam logic [7:0]  RST_PIPE3_LOW  = 8'hc4;
	localparam logic [2:0]  PIPE_EMPTY     = 3'h7;

	localparam logic [7:0] WMASK_ADDR_WIDTH = 8'h03;
	localparam logic [7:0] WMASK_CHANNEL    = 8'h7f;
	localparam logic [7:0] WMASK_RADIO_SET  = 8'hbf;

	localparam logic [3:0] COUNT_MAX      = 4'hf;
	localparam logic [2:0] ADDR_BYTES_MAX = 3'h5;

	typedef logic [4:0][7:0] rsa_addr_t;
	typedef rsa_addr_t [15:0] rsa_map_t;
endpackage

// ==== src/rsa_regs.sv ====
// radio status flags, transmit observe counters and receive addresses behind an SPI slave
// assumes event inputs come from radio logic on clk; sck, select and mosi are pins
// the host waits five clk periods after selecting before its first sck edge

module rsa_regs
	import rsa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        sck,
	input  wire logic        spiSelect_n,
	input  wire logic        spiMosi,
	output logic             spiMiso,
	output logic             spiMisoOe_n,
	input  wire logic        rxPayloadIn,
	input  wire logic [2:0]  rxPipeIn,
	input  wire logic        rxFifoEmptyIn,
	input  wire logic        txFifoFullIn,
	input  wire logic        txPacketDoneIn,
	input  wire logic        ackReceivedIn,
	input  wire logic        autoAckOn,
	input  wire logic        retryLimitIn,
	input  wire logic        packetLostIn,
	input  wire logic        retransmitIn,
	input  wire logic        newPacketIn,
	input  wire logic        powerDetectIn,
	output logic [1:0]       txPowerLevel,
	output logic [6:0]       channelSelect,
	output logic [1:0]       addressWidthField,
	output logic [3:0]       retryDelayField,
	output logic [3:0]       retryLimitField,
	output logic             carrierTestEnable,
	output logic             lowRateSelect,
	output logic             highRateSelect,
	output logic             commHalt,
	output logic [39:0]      pipe0ReceiveAddress,
	output logic [39:0]      pipe1ReceiveAddress,
	output logic [39:0]      pipe2ReceiveAddress,
	output logic [39:0]      pipe3ReceiveAddress
);
	rsa_link_if lnk();

	rsa_spi_link u_link (
		.sck         (sck),
		.spiSelect_n (spiSelect_n),
		.mosiPin     (spiMosi),
		.reset_n     (reset_n),
		.lnk         (lnk.link),
		.misoBit     (spiMiso)
	);

	logic       selS1_reg;
	logic       selS2_reg;
	logic       selS3_reg;
	logic       frameIdle_reg;
	logic       tglS1_reg;
	logic       tglS2_reg;
	logic       tglS3_reg;
	logic       tglSeen_reg;
	logic       byteEvt;
	logic       cmdEvt;
	logic       wrEvt;
	logic [7:0] wrByte;
	logic [7:0] curCmd_reg;
	logic [2:0] dataIdx_reg;

	logic       rxPayloadReadyFlag_reg;
	logic       txSentFlag_reg;
	logic       retryLimitFlag_reg;
	logic       txSentSet;
	logic [7:0] statusClr;
	logic [2:0] pipeNum_reg;
	logic       txFull_reg;
	logic [3:0] lostPacketCount_reg;
	logic [3:0] retryCount_reg;
	logic       receivedPowerDetect_reg;
	logic [7:0] statusByte;

	rsa_addr_t  pipe0_reg;
	rsa_addr_t  pipe1_reg;
	logic [7:0] pipe2Low_reg;
	logic [7:0] pipe3Low_reg;
	logic [7:0] addressWidthSetup_reg;
	logic [7:0] retransmitSetup_reg;
	logic [7:0] channelSelect_reg;
	logic [7:0] radioSetup_reg;
	logic       misoOe_n_reg;
	rsa_map_t   mapNext;

	// a data byte lands in the addressed register under a write command
	function automatic logic wrAt(input logic [4:0] ofs);
		return wrEvt && (curCmd_reg[4:0] == ofs);
	endfunction

	// bytes of a long address taken per write; code 00 is illegal and acts as three
	function automatic logic [2:0] addrBytes(input logic [1:0] code);
		unique case (code)
			2'h2:    return 3'h4;
			2'h3:    return 3'h5;
			default: return 3'h3;
		endcase
	endfunction

	// select pin: three flops, change counts when the last two agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			selS1_reg     <= 1'b1;
			selS2_reg     <= 1'b1;
			selS3_reg     <= 1'b1;
			frameIdle_reg <= 1'b1;
		end else begin
			selS1_reg <= spiSelect_n;
			selS2_reg <= selS1_reg;
			selS3_reg <= selS2_reg;
			if (selS2_reg == selS3_reg)
				frameIdle_reg <= selS3_reg;
		end
	end

	// byte event toggle from the sck side; the byte itself holds for a byte time
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tglS1_reg   <= 1'b0;
			tglS2_reg   <= 1'b0;
			tglS3_reg   <= 1'b0;
			tglSeen_reg <= 1'b0;
		end else begin
			tglS1_reg <= lnk.evtToggle;
			tglS2_reg <= tglS1_reg;
			tglS3_reg <= tglS2_reg;
			if (tglS2_reg == tglS3_reg)
				tglSeen_reg <= tglS3_reg;
		end
	end

	assign byteEvt = (tglS2_reg == tglS3_reg) && (tglS3_reg != tglSeen_reg);
	assign cmdEvt  = byteEvt && lnk.evtIsCmd;
	assign wrEvt   = byteEvt && !lnk.evtIsCmd && (curCmd_reg[7:5] == CMD_WRITE);
	assign wrByte  = lnk.evtByte;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			curCmd_reg  <= 8'h00;
			dataIdx_reg <= 3'h0;
		end else if (cmdEvt) begin
			curCmd_reg  <= wrByte;
			dataIdx_reg <= 3'h0;
		end else if (byteEvt && dataIdx_reg != 3'h7) begin
			dataIdx_reg <= dataIdx_reg + 3'h1;
		end
	end

	// interrupt flags: a hardware set in the clearing cycle wins
	assign txSentSet = autoAckOn ? ackReceivedIn : txPacketDoneIn;
	// only one bits of a status write clear; zero bits and read-only fields do nothing
	assign statusClr = wrAt(OFS_STATUS) ? wrByte : 8'h00;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rxPayloadReadyFlag_reg <= 1'b0;
			txSentFlag_reg         <= 1'b0;
			retryLimitFlag_reg     <= 1'b0;
		end else begin
			rxPayloadReadyFlag_reg <= rxPayloadIn | (rxPayloadReadyFlag_reg & ~statusClr[ST_RX_READY]);
			txSentFlag_reg         <= txSentSet | (txSentFlag_reg & ~statusClr[ST_TX_SENT]);
			retryLimitFlag_reg     <= retryLimitIn | (retryLimitFlag_reg & ~statusClr[ST_RETRY_LIM]);
		end
	end

	// read-only status fields follow the FIFOs and power detect follows its input; host writes never reach them
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pipeNum_reg             <= PIPE_EMPTY;
			txFull_reg              <= 1'b0;
			receivedPowerDetect_reg <= 1'b0;
		end else begin
			pipeNum_reg             <= rxFifoEmptyIn ? PIPE_EMPTY : rxPipeIn;
			txFull_reg              <= txFifoFullIn;
			receivedPowerDetect_reg <= powerDetectIn;
		end
	end

	// a loss in the same cycle as a channel write still counts once
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lostPacketCount_reg <= 4'h0;
		end else if (wrAt(OFS_CHANNEL)) begin
			lostPacketCount_reg <= packetLostIn ? 4'h1 : 4'h0;
		end else if (packetLostIn && lostPacketCount_reg != COUNT_MAX) begin
			lostPacketCount_reg <= lostPacketCount_reg + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			retryCount_reg <= 4'h0;
		end else if (newPacketIn) begin
			retryCount_reg <= 4'h0;
		end else if (retransmitIn && retryCount_reg != COUNT_MAX) begin
			retryCount_reg <= retryCount_reg + 4'h1;
		end
	end

	// setup registers; reserved bits are masked so they keep reading zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			addressWidthSetup_reg <= RST_ADDR_WIDTH;
			retransmitSetup_reg   <= RST_RETRANSMIT;
			channelSelect_reg     <= RST_CHANNEL;
			radioSetup_reg        <= RST_RADIO_SET;
		end else begin
			if (wrAt(OFS_ADDR_WIDTH))
				addressWidthSetup_reg <= wrByte & WMASK_ADDR_WIDTH;
			if (wrAt(OFS_RETRANSMIT))
				retransmitSetup_reg <= wrByte;
			if (wrAt(OFS_CHANNEL))
				channelSelect_reg <= wrByte & WMASK_CHANNEL;
			if (wrAt(OFS_RADIO_SET))
				radioSetup_reg <= wrByte & WMASK_RADIO_SET;
		end
	end

	// bytes past the configured width are dropped
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pipe0_reg    <= RST_PIPE0_ADDR;
			pipe1_reg    <= RST_PIPE1_ADDR;
			pipe2Low_reg <= RST_PIPE2_LOW;
			pipe3Low_reg <= RST_PIPE3_LOW;
		end else begin
			if (wrAt(OFS_PIPE0_ADDR) && dataIdx_reg < addrBytes(addressWidthSetup_reg[1:0]))
				pipe0_reg[dataIdx_reg] <= wrByte;
			if (wrAt(OFS_PIPE1_ADDR) && dataIdx_reg < addrBytes(addressWidthSetup_reg[1:0]))
				pipe1_reg[dataIdx_reg] <= wrByte;
			if (wrAt(OFS_PIPE2_LOW) && dataIdx_reg == 3'h0)
				pipe2Low_reg <= wrByte;
			if (wrAt(OFS_PIPE3_LOW) && dataIdx_reg == 3'h0)
				pipe3Low_reg <= wrByte;
		end
	end

	assign statusByte = {1'b0, rxPayloadReadyFlag_reg, txSentFlag_reg, retryLimitFlag_reg, pipeNum_reg, txFull_reg};

	always_comb begin
		mapNext = '0;
		mapNext[4'(OFS_ADDR_WIDTH)][0] = addressWidthSetup_reg;
		mapNext[4'(OFS_RETRANSMIT)][0] = retransmitSetup_reg;
		mapNext[4'(OFS_CHANNEL)][0]    = channelSelect_reg;
		mapNext[4'(OFS_RADIO_SET)][0]  = radioSetup_reg;
		mapNext[4'(OFS_STATUS)][0]     = statusByte;
		mapNext[4'(OFS_OBSERVE)][0]    = {lostPacketCount_reg, retryCount_reg};
		mapNext[4'(OFS_POWER_DET)][0]  = {7'h00, receivedPowerDetect_reg};
		mapNext[4'(OFS_PIPE0_ADDR)]    = pipe0_reg;
		mapNext[4'(OFS_PIPE1_ADDR)]    = pipe1_reg;
		mapNext[4'(OFS_PIPE2_LOW)][0]  = pipe2Low_reg;
		mapNext[4'(OFS_PIPE3_LOW)][0]  = pipe3Low_reg;
	end

	// snapshots freeze for the frame, so the sck side reads a still value;
	// the status shifted out is therefore the one taken when frameIdle_reg falls, four clk edges after select
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lnk.statusSnap <= 8'h00;
			lnk.regSnap    <= '0;
			misoOe_n_reg   <= 1'b1;
		end else begin
			misoOe_n_reg <= frameIdle_reg;
			if (frameIdle_reg) begin
				lnk.statusSnap <= statusByte;
				lnk.regSnap    <= mapNext;
			end
		end
	end

	assign spiMisoOe_n         = misoOe_n_reg;
	assign txPowerLevel        = radioSetup_reg[SET_PWR_LSB +: 2];
	assign carrierTestEnable   = radioSetup_reg[SET_CARRIER];
	assign lowRateSelect       = radioSetup_reg[SET_LOW_RATE];
	assign highRateSelect      = radioSetup_reg[SET_HI_RATE];
	assign channelSelect       = channelSelect_reg[6:0];
	assign addressWidthField   = addressWidthSetup_reg[1:0];
	assign retryDelayField     = retransmitSetup_reg[RETR_DLY_LSB +: 4];
	assign retryLimitField     = retransmitSetup_reg[3:0];
	assign commHalt            = retryLimitFlag_reg;
	assign pipe0ReceiveAddress = pipe0_reg;
	assign pipe1ReceiveAddress = pipe1_reg;
	assign pipe2ReceiveAddress = {pipe1_reg[4:1], pipe2Low_reg};
	assign pipe3ReceiveAddress = {pipe1_reg[4:1], pipe3Low_reg};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_power_write;
		wrAt(OFS_RADIO_SET) |=> txPowerLevel == $past(wrByte[2:1]);
	endproperty
	a_power_write: assert property (p_power_write)
		else $error("power level did not follow setup write");

	property p_rx_set_wins;
		rxPayloadIn |=> rxPayloadReadyFlag_reg && statusByte[ST_RX_READY];
	endproperty
	a_rx_set_wins: assert property (p_rx_set_wins)
		else $error("payload ready flag lost a set");

	property p_sent_waits_ack;
		autoAckOn && !ackReceivedIn && !txSentFlag_reg |=> !txSentFlag_reg;
	endproperty
	a_sent_waits_ack: assert property (p_sent_waits_ack)
		else $error("sent flag set without acknowledge");

	property p_halt_holds;
		retryLimitIn ##1 !(wrAt(OFS_STATUS) && wrByte[ST_RETRY_LIM]) |=> commHalt;
	endproperty
	a_halt_holds: assert property (p_halt_holds)
		else $error("halt dropped without a clearing write");

	property p_pipe_empty;
		rxFifoEmptyIn |=> statusByte[3:1] == PIPE_EMPTY;
	endproperty
	a_pipe_empty: assert property (p_pipe_empty)
		else $error("pipe number not empty code");

	property p_tx_full;
		txFifoFullIn |=> statusByte[0] ##1 1'b1;
	endproperty
	a_tx_full: assert property (p_tx_full)
		else $error("transmit full not shown");

	property p_lost_saturates;
		lostPacketCount_reg == COUNT_MAX && !wrAt(OFS_CHANNEL) |=> lostPacketCount_reg == COUNT_MAX;
	endproperty
	a_lost_saturates: assert property (p_lost_saturates)
		else $error("lost count left saturation");

	property p_retry_restart;
		newPacketIn |=> retryCount_reg == 4'h0;
	endproperty
	a_retry_restart: assert property (p_retry_restart)
		else $error("retry count not restarted");

	property p_channel_clears;
		wrAt(OFS_CHANNEL) && !packetLostIn |=> lostPacketCount_reg == 4'h0 && channelSelect == $past(wrByte[6:0]);
	endproperty
	a_channel_clears: assert property (p_channel_clears)
		else $error("channel write did not clear lost count");

	property p_zero_keeps;
		wrAt(OFS_STATUS) && !wrByte[ST_TX_SENT] |=> txSentFlag_reg == $past(txSentFlag_reg | txSentSet);
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("zero write changed sent flag");
endmodule

// ==== src/rsa_spi_link.sv ====
// SPI shifter on the serial clock: host samples on falling sck, device drives on rising
// assumes sck idles low and only toggles while the select is low
module rsa_spi_link
	import rsa_pkg::*;
(
	input  wire logic sck,
	input  wire logic spiSelect_n,
	input  wire logic mosiPin,
	input  wire logic reset_n,
	rsa_link_if.link  lnk,
	output logic      misoBit
);
	logic [2:0] bitCnt_reg;
	logic [2:0] byteCnt_reg;
	logic [6:0] shiftIn_reg;
	logic [7:0] cmd_reg;
	logic [7:0] outShift_reg;
	logic [7:0] loadByte;
	logic       frameRst;

	// the select ends the frame, since sck gives no edge after the last bit
	assign frameRst = spiSelect_n | ~reset_n;

	always_ff @(negedge sck or posedge frameRst) begin
		if (frameRst) begin
			bitCnt_reg  <= 3'h0;
			byteCnt_reg <= 3'h0;
		end else begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			if (bitCnt_reg == 3'h7 && byteCnt_reg != 3'h7)
				byteCnt_reg <= byteCnt_reg + 3'h1;
		end
	end

	always_ff @(negedge sck or negedge reset_n) begin
		if (!reset_n) begin
			shiftIn_reg   <= 7'h00;
			cmd_reg       <= 8'h00;
			lnk.evtByte   <= 8'h00;
			lnk.evtIsCmd  <= 1'b0;
			lnk.evtToggle <= 1'b0;
		end else begin
			shiftIn_reg <= {shiftIn_reg[5:0], mosiPin};
			if (bitCnt_reg == 3'h7) begin
				lnk.evtByte   <= {shiftIn_reg, mosiPin};
				lnk.evtIsCmd  <= (byteCnt_reg == 3'h0);
				lnk.evtToggle <= ~lnk.evtToggle;
				if (byteCnt_reg == 3'h0)
					cmd_reg <= {shiftIn_reg, mosiPin};
			end
		end
	end

	// status goes out under the command byte, read data under the bytes after it
	always_comb begin
		loadByte = 8'h00;
		if (byteCnt_reg == 3'h0)
			loadByte = lnk.statusSnap;
		else if (cmd_reg[7:5] == CMD_READ && !cmd_reg[4] && byteCnt_reg <= ADDR_BYTES_MAX)
			loadByte = lnk.regSnap[cmd_reg[3:0]][byteCnt_reg - 3'h1];
	end

	always_ff @(posedge sck or posedge frameRst) begin
		if (frameRst) begin
			misoBit      <= 1'b0;
			outShift_reg <= 8'h00;
		end else if (bitCnt_reg == 3'h0) begin
			misoBit      <= loadByte[7];
			outShift_reg <= {loadByte[6:0], 1'b0};
		end else begin
			misoBit      <= outShift_reg[7];
			outShift_reg <= {outShift_reg[6:0], 1'b0};
		end
	end
endmodule

// ==== tb/rsa_regs_tb.sv ====
// self-checking bench for the status/address register bank, reached over SPI
// assumes radio events are one-clk pulses driven at rising clk
module rsa_regs_tb import rsa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset_n;
	logic        sck;
	logic        spiSelect_n;
	logic        spiMosi;
	logic        spiMiso;
	logic        spiMisoOe_n;
	wire logic   misoLine;
	logic [6:0]  evt;
	logic [2:0]  rxPipe;
	logic        rxEmpty;
	logic        txFull;
	logic        autoAck;
	logic        powerDet;
	logic [1:0]  txPowerLevel;
	logic [6:0]  channelSelect;
	logic [1:0]  addressWidthField;
	logic [3:0]  retryDelayField;
	logic [3:0]  retryLimitField;
	logic        carrierTestEnable;
	logic        lowRateSelect;
	logic        highRateSelect;
	logic [39:0] pipe0Addr;
	logic [39:0] pipe1Addr;
	logic [39:0] pipe2Addr;
	logic [39:0] pipe3Addr;
	logic        commHalt;
	logic [7:0]  lastStat;
	int          n_errors;
	int          total_checks;

	// an undriven pin must not read as the last bit
	assign misoLine = spiMisoOe_n ? ~spiMiso : spiMiso;

	rsa_spi_host host_u (.sck(sck), .spiSelect_n(spiSelect_n), .spiMosi(spiMosi), .spiMiso(misoLine));

	rsa_regs dut_u (
		.clk(clk), .reset_n(reset_n), .sck(sck), .spiSelect_n(spiSelect_n), .spiMosi(spiMosi),
		.spiMiso(spiMiso), .spiMisoOe_n(spiMisoOe_n), .rxPayloadIn(evt[0]), .rxPipeIn(rxPipe),
		.rxFifoEmptyIn(rxEmpty), .txFifoFullIn(txFull), .txPacketDoneIn(evt[1]), .ackReceivedIn(evt[2]),
		.autoAckOn(autoAck), .retryLimitIn(evt[3]), .packetLostIn(evt[4]), .retransmitIn(evt[5]),
		.newPacketIn(evt[6]), .powerDetectIn(powerDet), .txPowerLevel(txPowerLevel),
		.channelSelect(channelSelect), .addressWidthField(addressWidthField),
		.retryDelayField(retryDelayField), .retryLimitField(retryLimitField),
		.carrierTestEnable(carrierTestEnable), .lowRateSelect(lowRateSelect), .highRateSelect(highRateSelect),
		.commHalt(commHalt), .pipe0ReceiveAddress(pipe0Addr), .pipe1ReceiveAddress(pipe1Addr),
		.pipe2ReceiveAddress(pipe2Addr), .pipe3ReceiveAddress(pipe3Addr)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input int n, input logic [39:0] d);
		logic [39:0] unused;
		host_u.frame({CMD_WRITE, a}, n, d, lastStat, unused);
	endtask

	task automatic rdchk(input logic [4:0] a, input int n, input logic [39:0] exp);
		logic [39:0] d;
		host_u.frame({CMD_READ, a}, n, 40'h0, lastStat, d);
		chk(d, exp);
	endtask

	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge clk);
			evt[i] <= 1'b1;
			@(posedge clk);
			evt[i] <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask

	// hang guard
	initial begin
		#5000000;
		n_errors++;
		print_verdict();
	end

	initial begin
		reset_n = 1'b0;
		evt = '0;
		rxPipe = 3'h0;
		rxEmpty = 1'b1;
		txFull = 1'b0;
		autoAck = 1'b0;
		powerDet = 1'b0;
		n_errors = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(spiMisoOe_n, 1'b1);
		chk(txPowerLevel, 2'h3);
		chk({carrierTestEnable, lowRateSelect, highRateSelect}, 3'h1);
		chk({retryDelayField, retryLimitField}, 8'h03);
		rdchk(OFS_STATUS, 1, 40'h0e);
		chk(lastStat, 8'h0e);
		rdchk(OFS_OBSERVE, 1, 40'h00);
		rdchk(OFS_POWER_DET, 1, 40'h00);
		rdchk(OFS_ADDR_WIDTH, 1, 40'h03);
		rdchk(OFS_RETRANSMIT, 1, 40'h03);
		rdchk(OFS_CHANNEL, 1, 40'h02);
		rdchk(OFS_RADIO_SET, 1, 40'h0e);
		rdchk(OFS_PIPE0_ADDR, 5, 40'he7e7e7e7e7);
		rdchk(OFS_PIPE1_ADDR, 5, 40'hc2c2c2c2c2);
		rdchk(OFS_PIPE2_LOW, 1, 40'hc3);
		rdchk(OFS_PIPE3_LOW, 1, 40'hc4);
		chk(pipe3Addr, 40'hc2c2c2c2c4);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_RADIO_SET, 1, {32'h0, 5'h01, c[1:0], 1'b0});
			chk(txPowerLevel, c[1:0]);
		end
		// reserved bit 6 of radio setup must not stick
		wr(OFS_RADIO_SET, 1, 40'he6);
		chk({carrierTestEnable, lowRateSelect, highRateSelect}, 3'h6);
		rdchk(OFS_RADIO_SET, 1, 40'ha6);
		wr(OFS_RETRANSMIT, 1, 40'h5a);
		chk({retryDelayField, retryLimitField}, 8'h5a);
		rdchk(OFS_RETRANSMIT, 1, 40'h5a);
		pulse(0, 1);
		pulse(1, 1);
		pulse(3, 1);
		chk(commHalt, 1'b1);
		rdchk(OFS_STATUS, 1, 40'h7e);
		wr(OFS_STATUS, 1, 40'h0f);
		rdchk(OFS_STATUS, 1, 40'h7e);
		wr(OFS_STATUS, 1, 40'h40);
		rdchk(OFS_STATUS, 1, 40'h3e);
		wr(OFS_STATUS, 1, 40'h30);
		chk(commHalt, 1'b0);
		@(posedge clk);
		autoAck <= 1'b1;
		pulse(1, 1);
		rdchk(OFS_STATUS, 1, 40'h0e);
		pulse(2, 1);
		rdchk(OFS_STATUS, 1, 40'h2e);
		wr(OFS_STATUS, 1, 40'h20);
		for (int p = 0; p < 6; p++) begin
			@(posedge clk);
			rxEmpty <= 1'b0;
			rxPipe <= p[2:0];
			txFull <= 1'b1;
			rdchk(OFS_STATUS, 1, {36'h0, p[2:0], 1'b1});
			chk(lastStat, {4'h0, p[2:0], 1'b1});
		end
		@(posedge clk);
		rxEmpty <= 1'b1;
		txFull <= 1'b0;
		pulse(4, 17);
		pulse(5, 3);
		rdchk(OFS_OBSERVE, 1, 40'hf3);
		pulse(6, 1);
		rdchk(OFS_OBSERVE, 1, 40'hf0);
		wr(OFS_CHANNEL, 1, 40'h10);
		chk(channelSelect, 7'h10);
		rdchk(OFS_OBSERVE, 1, 40'h00);
		@(posedge clk);
		powerDet <= 1'b1;
		rdchk(OFS_POWER_DET, 1, 40'h01);
		wr(OFS_PIPE1_ADDR, 5, 40'h1122334455);
		chk(pipe1Addr, 40'h1122334455);
		chk(pipe2Addr, 40'h11223344c3);
		wr(OFS_ADDR_WIDTH, 1, 40'h01);
		chk(addressWidthField, 2'h1);
		wr(OFS_PIPE0_ADDR, 5, 40'haabbccddee);
		chk(pipe0Addr, 40'he7e7ccddee);
		wr(OFS_ADDR_WIDTH, 1, 40'h03);
		wr(OFS_PIPE3_LOW, 1, 40'h5a);
		chk(pipe3Addr, 40'h112233445a);
		wr(5'h1f, 1, 40'hff);
		rdchk(5'h1f, 1, 40'h00);
		wr(OFS_OBSERVE, 1, 40'hff);
		rdchk(OFS_OBSERVE, 1, 40'h00);
		print_verdict();
	end
endmodule

// ==== tb/rsa_spi_host.sv ====
// host model on the SPI pins: mode 1 frames, command byte then data bytes
// assumes the device wants five clk periods between select low and the first sck edge
module rsa_spi_host (
	output logic      sck,
	output logic      spiSelect_n,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sck = 1'b0;
		spiSelect_n = 1'b1;
		spiMosi = 1'b0;
	end

	// sck stands low between frames; the odd 13 ns keeps it out of phase with clk
	task automatic frame(input logic [7:0] cmd, input int nData, input logic [39:0] wData,
		output logic [7:0] stat, output logic [39:0] rData);
		logic [7:0] txByte;
		logic [7:0] rxByte;
		rData = '0;
		stat = '0;
		spiSelect_n <= 1'b0;
		#513;
		for (int k = 0; k <= nData; k++) begin
			txByte = cmd;
			if (k > 0) begin
				txByte = wData[8*k-8 +: 8];
			end
			for (int b = 7; b >= 0; b--) begin
				sck <= 1'b1;
				spiMosi <= txByte[b];
				#80;
				sck <= 1'b0;
				rxByte[b] = spiMiso;
				#80;
			end
			if (k == 0) begin
				stat = rxByte;
			end else begin
				rData[8*k-8 +: 8] = rxByte;
			end
			#160;
		end
		spiSelect_n <= 1'b1;
		// released line shows the inverse of its last bit
		spiMosi <= ~spiMosi;
		#1000;
	endtask
endmodule
